// ### include/brg_pkg.sv
// shared constants of the bit clock generator
package brg_pkg;

  ////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] BRG_OFS_MODE   = 8'h00; // channel_mode_register
  localparam logic [7:0] BRG_OFS_DIV    = 8'h04; // divisor_config_register
  localparam logic [7:0] BRG_OFS_STATUS = 8'h08; // generator state, read only

  ////////////////////////////////////////////////////////////////////////
  // channel_mode_register fields
  localparam int BRG_MODE_SPECIAL_LSB = 0;  // 4-bit operating mode, 0 = normal
  localparam int BRG_MODE_SPECIAL_W   = 4;
  localparam int BRG_MODE_SRC_LSB     = 4;  // clock_source_select, 2 bits
  localparam int BRG_MODE_SYNC_BIT    = 8;  // 1 = synchronous mode
  localparam int BRG_MODE_CLKO_BIT    = 18; // drive the serial clock pin, in sync mode only and not with the pin source
  localparam int BRG_MODE_OVER_BIT    = 19; // 1 = 8x oversampling
  localparam logic [31:0] BRG_MODE_MASK = 32'h000c_013f;

  // divisor_config_register fields
  localparam int BRG_DIV_CD_LSB = 0;  // clock_divisor, 16 bits
  localparam int BRG_DIV_FP_LSB = 16; // fractional_part, 3 bits
  localparam logic [31:0] BRG_DIV_MASK = 32'h0007_ffff;

  // reset values
  localparam logic [31:0] BRG_MODE_RST = 32'h0000_0000;
  localparam logic [31:0] BRG_DIV_RST  = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////
  // clock source codes
  typedef enum logic [1:0]
  {
    BRG_SRC_MAIN     = 2'b00,
    BRG_SRC_PRESCALE = 2'b01,
    BRG_SRC_SPARE    = 2'b10, // behaves as the main clock
    BRG_SRC_PIN      = 2'b11
  } brg_src_t;

  localparam logic [3:0] BRG_SPECIAL_NORMAL = 4'h0;
  localparam logic [4:0] BRG_OVS_16 = 5'h10;
  localparam logic [4:0] BRG_OVS_8  = 5'h08;
  localparam int BRG_FRAC_STEPS = 8; // fraction counts in eighths

  // axi4-lite responses
  localparam logic [1:0] BRG_RESP_OKAY   = 2'b00;
  localparam logic [1:0] BRG_RESP_SLVERR = 2'b10;

endpackage

// ### rtl/brg_gen.sv
// Operation
// - one bit clock shared by receiver, transmitter
// - source is main, prescaled main, or pin
// - 16-bit divider counts clock_divisor source ticks
// - divisor zero stops every bit clock except the sync pin source one
// - divisor one bypasses the divider
// - async: sample clock divided 16 or 8
// - oversampling bit set selects 8x
// - nonzero fraction enables eighth-step division
// - async rate is source/(8(2-over)(cd+fp/8))
// - fraction only in normal operating mode
// - sync bit clock is source over divisor
// - sync pin source feeds bit clock directly
// - main source keeps 50:50 for odd divisor
// - stopped clock resumes from held state
// - registers writable while clock is off
//
// Local design decisions: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps

module brg_gen
  import brg_pkg::*;
#(
  parameter int DIV_W    = 16,
  parameter int PRESCALE = 8
)
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address, data and response
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // peripheral clock gate from the power manager
  input  wire logic        periph_clk_on,
  // serial clock pin
  input  wire logic        sck_i,
  output logic             sck_o,
  output logic             sck_oe,
  // enables towards receiver and transmitter
  output logic             sample_tick,
  output logic             bit_tick
);
  import brg_pkg::*;

  // elaboration guard: counters below assume these ranges
  if (DIV_W < 2 || DIV_W > 16 || PRESCALE < 2 || PRESCALE > 256)
  begin : g_bad_param
    $error("brg_gen: DIV_W or PRESCALE out of range");
  end

  localparam int PS_W = $clog2(PRESCALE);
  localparam logic [PS_W-1:0] PS_LAST = PS_W'(PRESCALE - 1);

  ////////////////////////////////////////////////////////////////////////
  // configuration registers
  logic [31:0] mode_r;
  logic [31:0] div_r;
  logic [31:0] wdata_m;
  logic        wr_do;
  logic [7:0]  wr_addr;

  logic [1:0]       src_sel;
  logic             sync_mode;
  logic             over8;
  logic             clko;
  logic [DIV_W-1:0] cd;
  logic [2:0]       fp;
  logic             normal_mode;

  assign src_sel     = mode_r[BRG_MODE_SRC_LSB +: 2];
  assign sync_mode   = mode_r[BRG_MODE_SYNC_BIT];
  assign over8       = mode_r[BRG_MODE_OVER_BIT];
  assign clko        = mode_r[BRG_MODE_CLKO_BIT];
  assign cd          = div_r[BRG_DIV_CD_LSB +: DIV_W];
  assign fp          = div_r[BRG_DIV_FP_LSB +: 3];
  assign normal_mode = mode_r[BRG_MODE_SPECIAL_LSB +: BRG_MODE_SPECIAL_W] == BRG_SPECIAL_NORMAL;

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite write side: address and data are taken in either order
  logic       aw_have_r;
  logic       w_have_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;

  assign s_axi_awready = ~aw_have_r & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_have_r & ~s_axi_bvalid;
  assign wr_do   = aw_have_r & w_have_r & ~s_axi_bvalid;
  assign wr_addr = awaddr_r;

  // byte lanes merged onto the current contents of the addressed register
  always_comb
  begin
    wdata_m = (wr_addr == BRG_OFS_MODE) ? mode_r : div_r;
    for (int i = 0; i < 4; i++)
    begin
      if (wstrb_r[i])
      begin
        wdata_m[8*i +: 8] = wdata_r[8*i +: 8];
      end
    end
  end

  // capture halves of a write and raise the response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_r    <= 1'b0;
      w_have_r     <= 1'b0;
      awaddr_r     <= 8'h00;
      wdata_r      <= 32'h0000_0000;
      wstrb_r      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= BRG_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (wr_do)
      begin
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_addr == BRG_OFS_MODE || wr_addr == BRG_OFS_DIV) ?
                        BRG_RESP_OKAY : BRG_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // writes ignore the clock gate
  // settings land even while the generator is frozen
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode_r <= BRG_MODE_RST;
      div_r  <= BRG_DIV_RST;
    end
    else if (wr_do && wr_addr == BRG_OFS_MODE)
    begin
      mode_r <= wdata_m & BRG_MODE_MASK;
    end
    else if (wr_do && wr_addr == BRG_OFS_DIV && !(sync_mode && src_sel == BRG_SRC_PIN))
    begin
      div_r <= wdata_m & BRG_DIV_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin input: three stages, a change counts once stages two and three agree
  logic sck_s1_r;
  logic sck_s2_r;
  logic sck_s3_r;
  logic sck_lvl_r;
  logic pin_rise;

  // pin rate is far below main
  // filtering relies on each pin phase spanning several main cycles
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sck_s1_r  <= 1'b0;
      sck_s2_r  <= 1'b0;
      sck_s3_r  <= 1'b0;
      sck_lvl_r <= 1'b0;
    end
    else
    begin
      sck_s1_r <= sck_i;
      sck_s2_r <= sck_s1_r;
      sck_s3_r <= sck_s2_r;
      if (sck_s2_r == sck_s3_r)
      begin
        sck_lvl_r <= sck_s3_r;
      end
    end
  end

  assign pin_rise = (sck_s2_r == sck_s3_r) & sck_s3_r & ~sck_lvl_r;

  ////////////////////////////////////////////////////////////////////////
  // source selection
  logic [PS_W-1:0] ps_cnt_r;
  logic            src_en;
  logic            run;

  assign run = periph_clk_on;

  always_comb
  begin
    unique case (brg_src_t'(src_sel))
      BRG_SRC_MAIN:     src_en = 1'b1;
      BRG_SRC_PRESCALE: src_en = (ps_cnt_r == PS_LAST);
      BRG_SRC_SPARE:    src_en = 1'b1;
      BRG_SRC_PIN:      src_en = pin_rise;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ps_cnt_r <= '0;
    end
    else if (run)
    begin
      ps_cnt_r <= (ps_cnt_r == PS_LAST) ? '0 : ps_cnt_r + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // integer divider with fractional stretch
  logic [DIV_W-1:0] cnt_r;
  logic [2:0]       acc_r;
  logic             ext_r;
  logic [DIV_W:0]   limit;
  logic             frac_on;
  logic             div_end;
  logic [3:0]       acc_sum;
  logic             ext_pin;

  assign frac_on = (fp != 3'd0) & normal_mode & ~sync_mode & (cd > 1);
  // period is cd source ticks, one longer when stretched
  assign limit   = {1'b0, cd} - 1'b1 + (DIV_W+1)'(ext_r & frac_on);
  assign div_end = src_en & ({1'b0, cnt_r} >= limit);
  assign acc_sum = {1'b0, acc_r} + {1'b0, fp};
  assign ext_pin = sync_mode & (src_sel == BRG_SRC_PIN);

  // eighths accumulate into extra source ticks
  // the carry of acc + fp stretches the next period by one tick
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_r <= '0;
      acc_r <= 3'd0;
      ext_r <= 1'b0;
    end
    else if (cd == '0)
    begin
      cnt_r <= '0;
      ext_r <= 1'b0;
    end
    else if (run && src_en)
    begin
      if (div_end)
      begin
        cnt_r <= '0;
        acc_r <= frac_on ? acc_sum[2:0] : 3'd0;
        ext_r <= frac_on & acc_sum[3];
      end
      else
      begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // oversampling stage and tick outputs
  logic [4:0] ovs_cnt_r;
  logic [4:0] ovs_last;
  logic       samp;

  // 8x when set, 16x when clear
  assign ovs_last = (over8 ? BRG_OVS_8 : BRG_OVS_16) - 5'd1;
  // cd of one passes each source tick
  assign samp     = run & (cd != '0) & div_end;

  // sample ticks counted down to bit ticks
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ovs_cnt_r <= 5'd0;
    end
    else if (sync_mode || cd == '0)
    begin
      ovs_cnt_r <= 5'd0;
    end
    else if (samp)
    begin
      ovs_cnt_r <= (ovs_cnt_r >= ovs_last) ? 5'd0 : ovs_cnt_r + 5'd1;
    end
  end

  // one-cycle enables in the main domain
  // the single bit_tick serves both directions
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sample_tick <= 1'b0;
      bit_tick    <= 1'b0;
    end
    // pin edge is the bit clock
    else if (ext_pin)
    begin
      sample_tick <= run & pin_rise;
      bit_tick    <= run & pin_rise;
    end
    // sync rate is source over cd
    else if (sync_mode)
    begin
      sample_tick <= samp;
      bit_tick    <= samp;
    end
    else
    begin
      sample_tick <= samp;
      bit_tick    <= samp & (ovs_cnt_r >= ovs_last);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // serial clock pin output; level is pos ^ neg so both clock edges can move it
  logic sck_p_r;
  logic sck_n_r;
  logic fall_half;
  logic fall_pos;
  logic main_src;
  logic [DIV_W-1:0] half;

  assign main_src = (src_sel == BRG_SRC_MAIN) | (src_sel == BRG_SRC_SPARE);
  assign half     = cd >> 1;
  // odd divisor on the main clock falls on the negative edge
  // the falling aclk edge inside count cd/2 gives the missing half cycle
  assign fall_half = main_src & run & cd[0] & (cnt_r == half);
  // other cases fall on a whole source tick
  // even divisors split evenly; odd ones on slow sources come out uneven
  assign fall_pos = ~(main_src & cd[0]) & run & (cd != '0) &
                    ((cd == DIV_W'(1)) | (src_en & (cnt_r == half - 1'b1)));

  // rising edge with each divider wrap, falling edge at mid period
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sck_p_r <= 1'b0;
      sck_oe  <= 1'b0;
    end
    else
    begin
      sck_oe <= clko & sync_mode & ~ext_pin;
      if (samp)
      begin
        sck_p_r <= ~sck_n_r;
      end
      else if (fall_pos)
      begin
        sck_p_r <= sck_n_r;
      end
    end
  end

  // half-cycle fall for odd divisors on the main clock
  always_ff @(negedge aclk)
  begin
    if (!aresetn)
    begin
      sck_n_r <= 1'b0;
    end
    else if (fall_half)
    begin
      sck_n_r <= sck_p_r;
    end
  end

  // xor of two registers; either edge toggles the pin without a derived clock
  assign sck_o = sck_p_r ^ sck_n_r;

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite read side, one cycle after the address is taken
  logic [31:0] status;

  assign status = {sck_lvl_r, sck_o, run, ovs_cnt_r[3:0], ext_r, acc_r, 5'd0,
                   16'(cnt_r)};
  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= BRG_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= BRG_RESP_OKAY;
      unique case (s_axi_araddr)
        BRG_OFS_MODE:   s_axi_rdata <= mode_r;
        BRG_OFS_DIV:    s_axi_rdata <= div_r;
        BRG_OFS_STATUS: s_axi_rdata <= status;
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= BRG_RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ### testbench/brg_monitor.sv
`timescale 1ns/1ps
module brg_monitor
(
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // generator side
  input wire logic        periph_clk_on,
  input wire logic        sample_tick,
  input wire logic        bit_tick
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  ////////////////////////////////////////
  // both write halves land on one edge
  sequence both_taken_s;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence read_taken_s;
    s_axi_arvalid && s_axi_arready;
  endsequence

  reset_quiet_a: assert property (@(posedge aclk) disable iff (1'b0)
    !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !sample_tick && !bit_tick)
    else $error("activity right after reset");
  bit_in_sample_a: assert property (bit_tick |-> sample_tick)
    else $error("bit tick without sample tick");
  gated_idle_a: assert property (!periph_clk_on [*3] |-> !sample_tick && !bit_tick)
    else $error("tick while clock stopped");
  write_answer_a: assert property (both_taken_s |-> ##2 s_axi_bvalid)
    else $error("write not answered");
  read_answer_a: assert property (read_taken_s |=> s_axi_rvalid)
    else $error("read not answered");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
endmodule

// ### testbench/brg_pin_src.sv
`timescale 1ns/1ps
module brg_pin_src
#(
  parameter realtime HALF_NS = 110.0
)
(
  // frame enable and pin level
  input wire logic run,
  output logic     sck
);
  // slow pin clock
  // phases far above one main period; offset keeps edges off aclk edges
  initial
  begin
    sck = 1'b0;
    #7;
    forever
    begin
      #(HALF_NS);
      sck = run ? ~sck : 1'b0;
    end
  end
endmodule

// ### testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import brg_pkg::*;
  typedef struct
  {
    logic [31:0] m;
    logic [31:0] d;
    int          sp;
    int          bp;
  } brg_row_t;

  // bus and control drive
  logic        aclk, aresetn, clk_on, pin_run, pin_lvl;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d, e;
  logic [3:0]  wstrb;
  logic        awvalid, wvalid, bready, arvalid, rready;
  // design answers
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, r;
  logic        sck_i, sck_o, sck_oe, stk, btk;
  int          fail_count = 0, samples_checked = 0, cyc = 0, p, n;
  realtime     t0, hi, per;

  // mode, divisor, sample period, bit period
  // divisors chosen so every checked rate is exact
  brg_row_t rows [9] = '{
    '{32'h0000_0000, 32'h0000_0004, 4, 64},
    '{32'h0008_0000, 32'h0000_0003, 3, 24},
    '{32'h0008_0010, 32'h0000_0002, 16, 128},
    '{32'h0008_0000, 32'h0000_0001, 1, 8},
    '{32'h0008_0020, 32'h0000_0005, 5, 40},
    '{32'h0008_0000, 32'h0004_0002, 0, 20},
    '{32'h0008_0001, 32'h0004_0002, 2, 16},
    '{32'h0000_0100, 32'h0000_0003, 3, 3},
    '{32'h0008_0030, 32'h0000_0001, 11, 88}
  };

  brg_gen u_dut
  (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .periph_clk_on(clk_on), .sck_i(sck_i), .sck_o(sck_o), .sck_oe(sck_oe),
    .sample_tick(stk), .bit_tick(btk)
  );
  brg_pin_src u_pin (.run(pin_run), .sck(pin_lvl));
  // pin level resolved from both drivers
  assign sck_i = sck_oe ? sck_o : pin_lvl;

  ////////////////////////////////////////
  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // cut a hang short
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      test_done;
    end
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // each channel released only at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] s);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid)
      begin
        s = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] s);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid)
      begin
        v = rdata;
        s = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask

  // ticks read as levels, never as edges
  // cycles between two ticks; b picks the bit tick
  task automatic gap(input bit b, output int g);
    int w;
    w = 0;
    while ((b ? btk : stk) !== 1'b1 && w < 3000)
    begin
      @(posedge aclk);
      w++;
    end
    g = 0;
    do
    begin
      @(posedge aclk);
      g++;
    end while ((b ? btk : stk) !== 1'b1 && g < 3000);
  endtask

  ////////////////////////////////////////
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    clk_on = 1'b1;
    // the external source runs free, as an oscillator on the pin would
    pin_run = 1'b1;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    // ordinary rate cases
    foreach (rows[i])
    begin
      wr(BRG_OFS_MODE, rows[i].m, r);
      wr(BRG_OFS_DIV, rows[i].d, r);
      gap(0, p);
      gap(0, p);
      if (rows[i].sp != 0) chk(p, rows[i].sp, "sample period");
      gap(1, p);
      gap(1, p);
      chk(p, rows[i].bp, "bit period");
      $display("rate row %0d done", i);
    end
    // second reset in mid-run, then divisor zero
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(BRG_OFS_MODE, d, r);
    chk(d, BRG_MODE_RST, "mode reset");
    rd(BRG_OFS_DIV, d, r);
    chk(d, BRG_DIV_RST, "div reset");
    n = 0;
    repeat (300)
    begin
      @(posedge aclk);
      if (stk !== 1'b0 || btk !== 1'b0) n++;
    end
    chk(n, 0, "ticks at divisor zero");
    $display("reset test done");
    // field masks and an unmapped place; divisor first, sync pin mode would lock it
    wr(BRG_OFS_DIV, 32'hffff_ffff, r);
    rd(BRG_OFS_DIV, d, r);
    chk(d, BRG_DIV_MASK, "div mask");
    wstrb <= 4'h1;
    wr(BRG_OFS_DIV, 32'h0000_0000, r);
    wstrb <= 4'hf;
    rd(BRG_OFS_DIV, d, r);
    chk(d, 32'h0007_ff00, "byte strobe");
    wr(BRG_OFS_MODE, 32'hffff_ffff, r);
    rd(BRG_OFS_MODE, d, r);
    chk(d, BRG_MODE_MASK, "mode mask");
    wr(8'h0c, 32'h1234_5678, r);
    chk(32'(r), 32'(BRG_RESP_SLVERR), "unmapped write");
    rd(8'h0c, d, r);
    chk(d, 32'h0, "unmapped read data");
    chk(32'(r), 32'(BRG_RESP_SLVERR), "unmapped read");
    $display("map test done");
    // stop the clock, configure, resume
    wr(BRG_OFS_MODE, 32'h0008_0000, r);
    wr(BRG_OFS_DIV, 32'h0000_0004, r);
    clk_on <= 1'b0;
    wr(BRG_OFS_DIV, 32'h0000_0006, r);
    rd(BRG_OFS_DIV, d, r);
    chk(d, 32'h6, "write while stopped");
    rd(BRG_OFS_STATUS, e, r);
    rd(BRG_OFS_STATUS, d, r);
    chk(32'(d[15:0]), 32'(e[15:0]), "count held");
    clk_on <= 1'b1;
    gap(0, p);
    gap(0, p);
    chk(p, 6, "period after resume");
    $display("gating test done");
    // odd divisor on the main clock drives the pin evenly
    wr(BRG_OFS_MODE, 32'h0004_0100, r);
    wr(BRG_OFS_DIV, 32'h0000_0003, r);
    repeat (2) @(posedge sck_o);
    t0 = $realtime;
    @(negedge sck_o);
    hi = $realtime - t0;
    @(posedge sck_o);
    per = $realtime - t0;
    chk(32'(sck_oe), 32'h1, "pin driven");
    chk(int'(hi), 30, "pin high time");
    chk(int'(per), 60, "pin period");
    $display("duty test done");
    // pin clock feeds the bit clock directly
    // odd divisor on the main clock above, divisor 3 kept on the pin
    pin_run <= 1'b1;
    wr(BRG_OFS_MODE, 32'h0004_0130, r);
    wr(BRG_OFS_DIV, 32'h0000_0007, r);
    rd(BRG_OFS_DIV, d, r);
    chk(d, 32'h3, "divisor write dropped");
    chk(32'(sck_oe), 32'h0, "pin released");
    gap(1, p);
    gap(1, p);
    chk(p, 11, "pin bit period");
    pin_run <= 1'b0;
    $display("pin test done");
    test_done;
  end
endmodule

bind brg_gen brg_monitor u_mon
(
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .periph_clk_on, .sample_tick, .bit_tick
);
